//--- rtl/pmw_pkg.sv
// Shared constants, register map and carrier types for the power mode and wake-up controller.
package pmw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] OFS_MODE = 5'h00; // System mode register.
	localparam logic [4:0] OFS_CTRL = 5'h04; // Idle clock enable and software reset flag.
	localparam logic [4:0] OFS_WDOG = 5'h08; // Watchdog control.
	localparam logic [4:0] OFS_WAKE = 5'h0c; // Port A wake enable register.
	localparam logic [4:0] OFS_STAT = 5'h10; // Power-down, timeout and clock status.

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int MODE_DIV_LSB  = 5; // Clock divider select, three bits.
	localparam int MODE_LO_BIT   = 3; // Low oscillator ready flag, read only.
	localparam int MODE_HI_BIT   = 2; // High oscillator ready flag, read only.
	localparam int MODE_IDLE_BIT = 1; // Idle on halt enable.
	localparam int MODE_HSEL_BIT = 0; // High clock select.
	localparam int CTRL_SYS_BIT  = 7; // System clock kept running in idle.
	localparam int CTRL_SWR_BIT  = 0; // Watchdog control software reset flag.
	localparam int WDOG_CODE_LSB = 3; // Watchdog enable code, five bits.
	localparam int STAT_PD_BIT   = 0; // Power-down flag.
	localparam int STAT_TMO_BIT  = 1; // Watchdog timeout flag.
	localparam int STAT_SRC_BIT  = 2; // System clock taken from the high oscillator.
	localparam int STAT_HEN_BIT  = 3; // High oscillator running.
	localparam int STAT_PWR_LSB  = 4; // Power state, three bits.

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and codes.
	localparam logic [7:0] MODE_RST  = 8'h03;
	localparam logic [7:0] WDOG_RST  = 8'h53;
	localparam logic [4:0] CODE_EN_A = 5'h0a;
	localparam logic [4:0] CODE_EN_B = 5'h15;
	localparam logic [2:0] DIV_SUB_MAX = 3'h1; // Divider codes at or below this pick the sub clock.

	////////////////////////////////////////////////////////////////////////////////
	// Timing counts in system clock cycles.
	localparam logic [3:0] HI_SETTLE_CYC = 4'hf; // High oscillator ready after wake.
	// Watchdog terminal counts in sub clock ticks, indexed by the period select field.
	localparam logic [7:0][17:0] WDOG_LIMIT = {18'h3ffff, 18'h1ffff, 18'h0ffff, 18'h07fff,
		18'h03fff, 18'h00fff, 18'h003ff, 18'h000ff};

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [2:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE_OFF, PWR_IDLE_ON, PWR_WAKE} pmw_pwr_e;

	typedef struct packed {
		logic       sys_en;   // System clock to CPU side peripherals.
		logic       tb_en;    // Time base clock.
		logic       sub_en;   // Sub clock, always running.
		logic       hosc_en;  // High-speed oscillator enable.
		logic       hdiv_en;  // Divided high clock taps, including /16 and /64.
		logic       src_high; // System clock taken from the high oscillator.
		logic       full_rate;// Undivided high clock selected.
		logic [2:0] div_sel;  // Divider code applied to the high clock.
		logic       cpu_run;  // CPU may execute.
	} pmw_clk_s;

	typedef struct packed {
		logic resume;      // Continue at the instruction after halt.
		logic isr;         // Take the normal interrupt response.
		logic pc_sp_reset; // Reset program counter and stack pointer only.
		logic wdog_reset;  // Watchdog timeout warm reset of the device.
		logic code_reset;  // Device reset from an illegal watchdog enable code.
	} pmw_evt_s;

endpackage

//--- rtl/pmw_power_ctrl.sv
// Power mode, clock switching, wake-up and watchdog controller with Avalon-MM registers.
`timescale 1ns/1ps

// Function
// - Handing the system clock to the sub clock stops the high oscillator and taps.
// - Switch into slow mode completes only once the low oscillator ready flag is high.
// - High oscillator ready flag is readable; software checks it after switching back.
// - Halt with idle disabled enters sleep: system and time base clocks stop.
// - Halt with idle enabled, idle clock off: system clock stops, time base runs.
// - Halt with idle enabled, idle clock on: system clock runs, CPU stops.
// - Entering any power-down mode keeps memory, registers and port states unchanged.
// - Entering power-down clears the watchdog counter, which keeps counting.
// - Halt sets the power-down flag and clears the watchdog timeout flag.
// - Power-down wakes on enabled port A falling edge, interrupt or watchdog overflow.
// - Watchdog overflow in power-down sets timeout, wakes, resets only PC and stack.
// - Power-down flag cleared by power-up or watchdog clear, set by halt.
// - Each port A pin enabled individually to wake; resume after halt.
// - Disabled interrupt or full stack wake resumes after halt, request stays pending.
// - Enabled interrupt with free stack level wake takes normal interrupt response.
// - Interrupt already flagged before power-down cannot wake the device.
// - One settle counter; wake into fast mode runs only after high ready.
// - Watchdog counts sub clock ticks, ratio two to eight up to eighteen.
// - Watchdog control loads 0x53 on every reset except watchdog timeout reset.
// - Low oscillator ready rises two to three cycles after oscillator is stable.
// - High ready reads low in sleep and idle off, rises 15 cycles after wake.
// - Enable codes 01010 or 10101 enable watchdog; others reset after a delay.
module pmw_power_ctrl
	import pmw_pkg::*;
#(
	parameter int PA_W       = 8,  // Port A pins with wake capability.
	parameter int IRQ_W      = 4,  // Interrupt request lines.
	parameter int SRESET_CYC = 16  // Delay before an illegal enable code resets the device.
)(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [3:0]        avs_byteenable,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              halt_exec,
	input  wire logic              wdog_clear_exec,
	input  wire logic              warm_reset,
	input  wire logic              sub_clk_pin,
	input  wire logic              lo_osc_stable,
	input  wire logic [PA_W-1:0]   porta_pin,
	input  wire logic [IRQ_W-1:0]  irq_flag,
	input  wire logic [IRQ_W-1:0]  irq_enable,
	input  wire logic              stack_full,
	output pmw_clk_s               clk_ctl,
	output pmw_evt_s               wake_evt
);

	localparam int SR_W = $clog2(SRESET_CYC + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Whole state of the block.
	typedef struct packed {
		logic [2:0]       div_sel;
		logic             idle_en;
		logic             hsel;
		logic             lo_rdy;
		logic             hi_rdy;
		logic             sysclk_idle;
		logic             swr_flag;
		logic [7:0]       wdog_ctl;
		logic [PA_W-1:0]  wake_en;
		logic             pd_flag;
		logic             timeout_flag;
		pmw_pwr_e         pwr;
		logic             src_high;
		logic             hosc_en;
		logic [3:0]       settle;
		logic [2:0]       sub_sync;
		logic [1:0]       stab_sync;
		logic [PA_W-1:0]  pa_s1;
		logic [PA_W-1:0]  pa_s2;
		logic [PA_W-1:0]  pa_s3;
		logic [IRQ_W-1:0] irq_arm;
		logic             wk_pa;
		logic             wk_irq;
		logic             wk_wdog;
		logic [17:0]      wdog_cnt;
		logic [SR_W-1:0]  sreset_cnt;
		logic             ack;
		logic [31:0]      rdata;
		pmw_clk_s         clk;
		pmw_evt_s         evt;
	} pmw_state_s;

	localparam pmw_state_s ST_RST = '{
		div_sel:  MODE_RST[7:5],
		idle_en:  MODE_RST[MODE_IDLE_BIT],
		hsel:     MODE_RST[MODE_HSEL_BIT],
		wdog_ctl: WDOG_RST,
		pwr:      PWR_WAKE,
		src_high: 1'b1,
		hosc_en:  1'b1,
		clk:      '{sys_en: 1'b1, tb_en: 1'b1, sub_en: 1'b1, hosc_en: 1'b1, hdiv_en: 1'b1,
		            src_high: 1'b1, full_rate: 1'b1, div_sel: 3'h0, cpu_run: 1'b0},
		default:  '0
	};

	pmw_state_s s_q;
	pmw_state_s s_d;

	logic             bus_req;
	logic             wr_go;
	logic [7:0]       wbyte;
	logic [7:0]       rd_byte;
	logic             sub_tick;
	logic [PA_W-1:0]  pa_fall;
	logic             irq_hit;
	logic             want_high;
	logic             powered_down;
	logic             halt_go;
	logic             wdog_clr;
	logic             wdog_ovf;
	logic             code_ok;
	logic             src_ready;

	////////////////////////////////////////////////////////////////////////////////
	// Helper terms read by the next-state process.
	assign bus_req      = avs_read | avs_write;
	assign wr_go        = avs_write & s_q.ack & avs_byteenable[0];
	assign wbyte        = avs_writedata[7:0];
	assign sub_tick     = s_q.sub_sync[1] & ~s_q.sub_sync[2];
	assign powered_down = (s_q.pwr == PWR_SLEEP) || (s_q.pwr == PWR_IDLE_OFF) || (s_q.pwr == PWR_IDLE_ON);
	assign halt_go      = (s_q.pwr == PWR_RUN) && halt_exec;
	assign want_high    = s_q.hsel || (s_q.div_sel > DIV_SUB_MAX);
	// Per-pin falling edge qualified by its enable.
	assign pa_fall      = s_q.pa_s3 & ~s_q.pa_s2 & s_q.wake_en;
	// Only requests not already pending at halt may wake.
	assign irq_hit      = |(irq_flag & s_q.irq_arm);
	// Halt and the clear instruction restart the count.
	assign wdog_clr     = halt_go || wdog_clear_exec;
	// Overflow at the terminal count chosen by the period select.
	assign wdog_ovf     = sub_tick && !wdog_clr && (s_q.wdog_cnt == WDOG_LIMIT[s_q.wdog_ctl[2:0]]);
	// Only two enable codes are legal.
	assign code_ok      = (s_q.wdog_ctl[7:3] == CODE_EN_A) || (s_q.wdog_ctl[7:3] == CODE_EN_B);
	// The CPU restarts only when the clock it will run on is ready.
	assign src_ready    = s_q.src_high ? s_q.hi_rdy : s_q.lo_rdy;

	// Ready flags readable.
	// Read data selection; unmapped offsets read as zero.
	assign rd_byte =
		(avs_address == OFS_MODE) ? {s_q.div_sel, 1'b0, s_q.lo_rdy, s_q.hi_rdy, s_q.idle_en, s_q.hsel} :
		(avs_address == OFS_CTRL) ? {s_q.sysclk_idle, 6'h00, s_q.swr_flag} :
		(avs_address == OFS_WDOG) ? s_q.wdog_ctl :
		(avs_address == OFS_WAKE) ? 8'(s_q.wake_en) :
		(avs_address == OFS_STAT) ? {1'b0, s_q.pwr, s_q.hosc_en, s_q.src_high, s_q.timeout_flag, s_q.pd_flag} :
		8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb
	begin
		s_d     = s_q;
		s_d.evt = '0;

		// Pin and oscillator synchronisers; the first stage feeds only the second.
		s_d.sub_sync  = {s_q.sub_sync[1:0], sub_clk_pin};
		s_d.stab_sync = {s_q.stab_sync[0], lo_osc_stable};
		s_d.pa_s1     = porta_pin;
		s_d.pa_s2     = s_q.pa_s1;
		s_d.pa_s3     = s_q.pa_s2;
		// Low ready follows the synchronised stable level.
		s_d.lo_rdy    = s_q.stab_sync[1];

		// Bus slave: one wait cycle, read data captured on the first edge.
		s_d.ack = bus_req & ~s_q.ack;
		if (avs_read && !s_q.ack)
		begin
			s_d.rdata = {24'h000000, rd_byte};
		end
		if (wr_go)
		begin
			unique case (avs_address)
				OFS_MODE:
				begin
					s_d.div_sel = wbyte[7:5];
					s_d.idle_en = wbyte[MODE_IDLE_BIT];
					s_d.hsel    = wbyte[MODE_HSEL_BIT];
				end
				OFS_CTRL:
				begin
					s_d.sysclk_idle = wbyte[CTRL_SYS_BIT];
					s_d.swr_flag    = s_q.swr_flag & wbyte[CTRL_SWR_BIT];
				end
				OFS_WDOG: s_d.wdog_ctl = wbyte;
				OFS_WAKE: s_d.wake_en  = wbyte[PA_W-1:0];
				default: ;
			endcase
		end

		// The clear instruction drops the power-down flag.
		if (wdog_clear_exec)
		begin
			s_d.pd_flag = 1'b0;
		end

		// Power state sequencing.
		unique case (s_q.pwr)
			PWR_RUN:
			begin
				if (halt_exec)
				begin
					if (!s_q.idle_en)
					begin
						s_d.pwr = PWR_SLEEP;
					end
					// Idle clock enable picks which idle.
					else if (s_q.sysclk_idle)
					begin
						s_d.pwr = PWR_IDLE_ON;
					end
					else
					begin
						s_d.pwr = PWR_IDLE_OFF;
					end
					s_d.pd_flag      = 1'b1;
					s_d.timeout_flag = 1'b0;
					// Remember which requests were already flagged.
					s_d.irq_arm = ~irq_flag;
					// No register, memory or port state is touched on entry.
				end
			end
			PWR_SLEEP, PWR_IDLE_OFF, PWR_IDLE_ON:
			begin
				// Any of the three sources ends power-down.
				if (wdog_ovf || irq_hit || (|pa_fall))
				begin
					s_d.pwr     = PWR_WAKE;
					s_d.wk_wdog = wdog_ovf;
					s_d.wk_irq  = irq_hit;
					s_d.wk_pa   = |pa_fall;
				end
			end
			PWR_WAKE:
			begin
				// First instruction waits for the ready flag.
				if (src_ready)
				begin
					s_d.pwr     = PWR_RUN;
					s_d.wk_wdog = 1'b0;
					s_d.wk_irq  = 1'b0;
					s_d.wk_pa   = 1'b0;
					// Watchdog wake resets only PC and stack.
					if (s_q.wk_wdog)
					begin
						s_d.evt.pc_sp_reset = 1'b1;
					end
					// Enabled request with a free stack level is serviced.
					else if (s_q.wk_irq && (|(irq_flag & s_q.irq_arm & irq_enable)) && !stack_full)
					begin
						s_d.evt.isr = 1'b1;
					end
					// Otherwise continue after halt; the request stays pending.
					else if (s_q.wk_irq || s_q.wk_pa)
					begin
						s_d.evt.resume = 1'b1;
					end
				end
			end
			default: s_d.pwr = PWR_WAKE;
		endcase

		// Clock source selection; the old source is held until the new one is ready.
		if ((s_d.pwr == PWR_SLEEP) || (s_d.pwr == PWR_IDLE_OFF))
		begin
			s_d.hosc_en = 1'b0;
		end
		else if (want_high && !s_q.src_high)
		begin
			s_d.hosc_en = 1'b1;
			// Hand over only once the high oscillator is settled.
			if (s_q.hi_rdy)
			begin
				s_d.src_high = 1'b1;
			end
		end
		else if (!want_high && s_q.src_high)
		begin
			// Move to the sub clock when it is stable and stop the oscillator on the same edge.
			if (s_q.lo_rdy)
			begin
				s_d.src_high = 1'b0;
				s_d.hosc_en  = 1'b0;
			end
		end
		else
		begin
			s_d.hosc_en = s_q.src_high;
		end

		// Shared settle counter, ready flag drops with the oscillator.
		if (!s_q.hosc_en)
		begin
			s_d.settle = 4'h0;
		end
		else if (s_q.settle != (HI_SETTLE_CYC - 4'h1))
		begin
			s_d.settle = s_q.settle + 4'h1;
		end
		s_d.hi_rdy = s_d.hosc_en && s_q.hosc_en && (s_q.settle == (HI_SETTLE_CYC - 4'h1));

		// Watchdog count on sub clock ticks.
		if (wdog_clr || wdog_ovf)
		begin
			s_d.wdog_cnt = 18'h00000;
		end
		else if (sub_tick)
		begin
			s_d.wdog_cnt = s_q.wdog_cnt + 18'h00001;
		end
		// Overflow sets the timeout flag; a halt in the same cycle masks the overflow and the clear wins.
		if (wdog_ovf)
		begin
			s_d.timeout_flag = 1'b1;
			s_d.evt.wdog_reset = !powered_down;
		end

		// Illegal enable code resets the device after the delay.
		if (code_ok)
		begin
			s_d.sreset_cnt = '0;
		end
		else if (s_q.sreset_cnt == SR_W'(SRESET_CYC))
		begin
			s_d.sreset_cnt     = '0;
			s_d.evt.code_reset = 1'b1;
			s_d.swr_flag       = 1'b1;
			s_d.wdog_ctl       = WDOG_RST;
			s_d.wdog_cnt       = 18'h00000;
		end
		else
		begin
			s_d.sreset_cnt = s_q.sreset_cnt + SR_W'(1);
		end

		// Resets other than the watchdog timeout reload the control value.
		if (warm_reset)
		begin
			s_d.wdog_ctl = WDOG_RST;
		end

		// Registered clock controls derived from the next state.
		s_d.clk.sys_en  = (s_d.pwr != PWR_SLEEP) && (s_d.pwr != PWR_IDLE_OFF);
		s_d.clk.tb_en   = (s_d.pwr != PWR_SLEEP);
		s_d.clk.sub_en  = 1'b1;
		s_d.clk.hosc_en = s_d.hosc_en;
		// Divided taps stop with the oscillator.
		s_d.clk.hdiv_en  = s_d.hosc_en;
		s_d.clk.src_high = s_d.src_high;
		s_d.clk.cpu_run  = (s_d.pwr == PWR_RUN);
		if (s_d.src_high && want_high)
		begin
			s_d.clk.full_rate = s_q.hsel;
			s_d.clk.div_sel   = s_q.div_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs from the state register; waitrequest is also gated by the bus request.
	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = bus_req & ~s_q.ack;
	assign clk_ctl         = s_q.clk;
	assign wake_evt        = s_q.evt;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	property p_sub_stops_high;
		$fell(s_q.src_high) |-> !s_q.hosc_en && !s_q.clk.hdiv_en;
	endproperty
	a_sub_stops_high: assert property (p_sub_stops_high) else $error("High oscillator still on after switch.");

	property p_slow_needs_ready;
		$fell(s_q.src_high) |-> $past(s_q.lo_rdy);
	endproperty
	a_slow_needs_ready: assert property (p_slow_needs_ready) else $error("Slow switch without low ready.");

	property p_high_settle;
		($rose(s_q.hosc_en) ##0 (s_q.hosc_en throughout ##15 1'b1)) |-> s_q.hi_rdy ##0 $rose(s_q.hi_rdy);
	endproperty
	a_high_settle: assert property (p_high_settle) else $error("High ready not at 15 cycles.");

	property p_sleep_clocks;
		(s_q.pwr == PWR_SLEEP) |-> !s_q.clk.sys_en && !s_q.clk.tb_en && s_q.clk.sub_en && !s_q.hi_rdy;
	endproperty
	a_sleep_clocks: assert property (p_sleep_clocks) else $error("Sleep clock gating wrong.");

	property p_idle_off_clocks;
		(s_q.pwr == PWR_IDLE_OFF) |-> !s_q.clk.sys_en && s_q.clk.tb_en && !s_q.hi_rdy;
	endproperty
	a_idle_off_clocks: assert property (p_idle_off_clocks) else $error("Idle-off clock gating wrong.");

	property p_idle_on_clocks;
		(s_q.pwr == PWR_IDLE_ON) |-> s_q.clk.sys_en && s_q.clk.sub_en && !s_q.clk.cpu_run;
	endproperty
	a_idle_on_clocks: assert property (p_idle_on_clocks) else $error("Idle-on clock gating wrong.");

	property p_halt_flags;
		halt_go |=> s_q.pd_flag && !s_q.timeout_flag && (s_q.pwr != PWR_RUN) && (s_q.wdog_cnt == 18'h00000);
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("Halt did not update flags.");

	property p_wdog_wake;
		(wdog_ovf && powered_down) |=> s_q.timeout_flag && (s_q.pwr == PWR_WAKE) && !s_q.evt.wdog_reset;
	endproperty
	a_wdog_wake: assert property (p_wdog_wake) else $error("Watchdog overflow did not wake.");

	property p_fast_wake_waits;
		(s_q.pwr == PWR_WAKE && s_q.src_high) ##1 (s_q.pwr == PWR_RUN) |-> $past(s_q.hi_rdy);
	endproperty
	a_fast_wake_waits: assert property (p_fast_wake_waits) else $error("CPU ran before high ready.");

	property p_wdog_reload;
		warm_reset |=> (s_q.wdog_ctl == WDOG_RST);
	endproperty
	a_wdog_reload: assert property (p_wdog_reload) else $error("Watchdog control not reloaded.");

endmodule

//--- verification/pmw_tb.sv
// Self-checking register and power mode testbench for the power mode and wake-up controller.
`timescale 1ns/1ps
module tb;
	import pmw_pkg::*;
	logic             mclk;
	logic             rst_b;
	logic [4:0]       avs_address;
	logic             avs_read;
	logic             avs_write;
	logic [3:0]       avs_byteenable;
	logic [31:0]      avs_writedata;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic             halt_exec;
	logic             wdog_clear_exec;
	logic             warm_reset;
	logic             sub_clk_pin = 1'b0;
	logic             sub_run;
	logic             lo_osc_stable;
	logic [7:0]       porta_pin;
	logic [3:0]       irq_flag;
	logic [3:0]       irq_enable;
	logic             stack_full;
	pmw_clk_s         clk_ctl;
	pmw_evt_s         wake_evt;
	pmw_evt_s         e;
	int               num_errors;
	int               n_compared;

	////////////////////////////////////////////////////////////////////////////////
	// Device under test with default port widths.
	pmw_power_ctrl dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_exec(halt_exec),
		.wdog_clear_exec(wdog_clear_exec), .warm_reset(warm_reset), .sub_clk_pin(sub_clk_pin),
		.lo_osc_stable(lo_osc_stable), .porta_pin(porta_pin), .irq_flag(irq_flag),
		.irq_enable(irq_enable), .stack_full(stack_full), .clk_ctl(clk_ctl), .wake_evt(wake_evt));

	// Clock at 250 MHz.
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Fast sub clock for watchdog ticks, only while a scenario asks for it.
	always @(posedge mclk)
		if (sub_run)
			sub_clk_pin <= ~sub_clk_pin;

	// Cuts a hung run short.
	initial
	begin
		#200000;
		num_errors++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task close_out;
		$display("Counts: %0d mismatches in %0d compares", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is sampled low.
	task bus(input logic wr, input logic [4:0] a, input logic [7:0] wd, output logic [31:0] rd);
		int i;
		@(posedge mclk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= {24'h0, wd};
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50)
			chk(32'h1, 32'h0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task rdc(input logic [4:0] a, input logic [7:0] mask, input logic [7:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 8'h00, rd);
		chk(rd & {24'hffffff, mask}, {24'h0, exp});
	endtask

	// Halt pulse, then settle so that the new mode is visible.
	task halt;
		@(posedge mclk);
		halt_exec <= 1'b1;
		@(posedge mclk);
		halt_exec <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	// Waits for the first wake or reset event pulse and captures it.
	task wait_evt(input int lim);
		e = '0;
		for (int i = 0; i < lim; i++)
		begin
			@(posedge mclk);
			if (|wake_evt)
			begin
				e = wake_evt;
				break;
			end
		end
		chk({31'h0, |e}, 32'h1);
	endtask

	function automatic logic [31:0] cs();
		return {28'h0, clk_ctl.sys_en, clk_ctl.tb_en, clk_ctl.sub_en, clk_ctl.cpu_run};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		{rst_b, avs_address, avs_read, avs_write, avs_writedata} = '0;
		{halt_exec, wdog_clear_exec, warm_reset, sub_run, lo_osc_stable} = '0;
		{irq_flag, irq_enable, stack_full, num_errors, n_compared} = '0;
		avs_byteenable = 4'hf;
		porta_pin = 8'hff;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (30) @(posedge mclk);
		// Reset values, unmapped place and read-only status.
		rdc(OFS_MODE, 8'hff, 8'h07);
		rdc(OFS_WDOG, 8'hff, 8'h53);
		rdc(OFS_WAKE, 8'hff, 8'h00);
		rdc(OFS_CTRL, 8'hff, 8'h00);
		rdc(5'h14, 8'hff, 8'h00);
		wr(OFS_STAT, 8'hff);
		rdc(OFS_STAT, 8'h7f, 8'h0c);
		// Slow switch waits for the low oscillator, then stops the high one.
		wr(OFS_MODE, 8'h00);
		repeat (10) @(posedge mclk);
		chk(clk_ctl.src_high, 1'b1);
		lo_osc_stable <= 1'b1;
		repeat (10) @(posedge mclk);
		chk({clk_ctl.src_high, clk_ctl.hosc_en, clk_ctl.hdiv_en}, 3'h0);
		rdc(OFS_MODE, 8'h08, 8'h08);
		wr(OFS_MODE, 8'h40);
		repeat (30) @(posedge mclk);
		chk({clk_ctl.src_high, clk_ctl.hosc_en, clk_ctl.full_rate, clk_ctl.div_sel}, 6'h32);
		rdc(OFS_MODE, 8'h04, 8'h04);
		// Watchdog overflow wakes from sleep.
		wr(OFS_MODE, 8'h01);
		wr(OFS_WDOG, 8'h50);
		halt();
		chk(cs(), 4'h2);
		rdc(OFS_MODE, 8'h04, 8'h00);
		sub_run <= 1'b1;
		wait_evt(3000);
		chk(e.pc_sp_reset, 1'b1);
		// A second overflow while running is a full watchdog reset that keeps the control value.
		wait_evt(3000);
		sub_run <= 1'b0;
		chk({e.wdog_reset, e.pc_sp_reset}, 2'b10);
		rdc(OFS_WDOG, 8'hff, 8'h50);
		rdc(OFS_STAT, 8'h73, 8'h03);
		rdc(OFS_WDOG, 8'hff, 8'h50);
		@(posedge mclk);
		wdog_clear_exec <= 1'b1;
		@(posedge mclk);
		wdog_clear_exec <= 1'b0;
		rdc(OFS_STAT, 8'h03, 8'h02);
		// Port A wake, disabled pin first.
		wr(OFS_WAKE, 8'h01);
		halt();
		rdc(OFS_STAT, 8'h73, 8'h11);
		porta_pin[1] <= 1'b0;
		repeat (20) @(posedge mclk);
		rdc(OFS_STAT, 8'h70, 8'h10);
		porta_pin[0] <= 1'b0;
		wait_evt(200);
		chk({27'h0, e.resume, 4'(cs())}, 32'h1f);
		porta_pin <= 8'hff;
		// Idle with clock off, stale interrupt ignored, enabled one serviced.
		wr(OFS_MODE, 8'h03);
		irq_flag   <= 4'h2;
		irq_enable <= 4'h3;
		halt();
		chk(cs(), 4'h6);
		repeat (20) @(posedge mclk);
		rdc(OFS_STAT, 8'h70, 8'h20);
		irq_flag <= 4'h3;
		wait_evt(200);
		chk(e.isr, 1'b1);
		irq_flag <= 4'h0;
		// Idle with clock on, interrupt with full stack resumes after halt.
		wr(OFS_CTRL, 8'h80);
		rdc(OFS_CTRL, 8'hff, 8'h80);
		stack_full <= 1'b1;
		irq_enable <= 4'h1;
		halt();
		chk(cs() & 4'hb, 4'ha);
		irq_flag <= 4'h1;
		wait_evt(200);
		chk({e.isr, e.resume}, 2'b01);
		{stack_full, irq_flag, irq_enable} <= '0;
		// Illegal enable code resets and reloads the watchdog control.
		wr(OFS_WDOG, 8'h00);
		wait_evt(200);
		chk(e.code_reset, 1'b1);
		rdc(OFS_WDOG, 8'hff, 8'h53);
		rdc(OFS_CTRL, 8'h01, 8'h01);
		wr(OFS_CTRL, 8'h00);
		rdc(OFS_CTRL, 8'hff, 8'h00);
		// Other reset sources reload the watchdog control.
		wr(OFS_WDOG, 8'h52);
		rdc(OFS_WDOG, 8'hff, 8'h52);
		@(posedge mclk);
		warm_reset <= 1'b1;
		@(posedge mclk);
		warm_reset <= 1'b0;
		rdc(OFS_WDOG, 8'hff, 8'h53);
		close_out();
	end
endmodule
